// ==== msbw_pkg.sv ====
package msbw_pkg;
  // mode pin patterns {hi,mid,lo}
  localparam logic [2:0] MODE_PINS_4 = 3'h4;
  localparam logic [2:0] MODE_PINS_5 = 3'h5;
  localparam logic [2:0] MODE_PINS_6 = 3'h6;
  localparam logic [2:0] MODE_PINS_7 = 3'h7;
  // register map
  localparam logic [3:0] ADDR_WIDTH_CFG = 4'h0;
  localparam logic [3:0] ADDR_MODE_STATUS = 4'h1;
  // reset values of the width register
  localparam logic [7:0] WIDTH_RESET_WIDE = 8'h00;
  localparam logic [7:0] WIDTH_RESET_NARROW = 8'hFF;
  localparam int USB_AREA_BIT = 6;
  typedef enum logic [1:0]
  {
    MSBW_MODE4 = 2'b00,
    MSBW_MODE5 = 2'b01,
    MSBW_MODE6 = 2'b10,
    MSBW_MODE7 = 2'b11
  } msbw_mode_t;
endpackage

// ==== msbw_decode.sv ====
`timescale 1ns/1ps
// combinational pin decoder; an invalid pattern falls back to single-chip
module msbw_decode
  import msbw_pkg::*;
(
  input wire logic [2:0] pins,
  output msbw_mode_t mode
);
  // decode the strap pattern
  always_comb
  begin
    if (pins == MODE_PINS_4)
      mode = MSBW_MODE4;
    else if (pins == MODE_PINS_5)
      mode = MSBW_MODE5;
    else if (pins == MODE_PINS_6)
      mode = MSBW_MODE6;
    else
      mode = MSBW_MODE7;
  end
endmodule

// ==== msbw_top.sv ====
`timescale 1ns/1ps
// Behaviour
// - The three mode pins decode 100/101/110/111 into modes 4/5/6/7.
// - Modes 4, 5 and 6 enable the external bus for memory and peripherals.
// - Mode 7 is single-chip and produces no external addresses.
// - On-chip ROM is off in modes 4 and 5 and on in modes 6 and 7.
// - The width register has one bit per area 7..0, 0 meaning 16-bit and 1 meaning 8-bit.
// - Reset loads the width register with all ones; the latch edge after release loads all ones in modes 5, 6, 7 and all zeros in mode 4.
// - If any area is 16-bit the whole external bus runs 16-bit, else it runs 8-bit.
// - On-chip memory and internal registers keep a fixed width, except the USB area which follows its bit.
module msbw_top
  import msbw_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic mode_pin_hi,
  input wire logic mode_pin_mid,
  input wire logic mode_pin_lo,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic [1:0] op_mode,
  output logic ext_bus_en,
  output logic ext_addr_en,
  output logic rom_en,
  output logic ext_bus_16bit,
  output logic [7:0] area_bus_width_config,
  output logic usb_area_8bit,
  output logic mode_valid
);
  msbw_mode_t pin_mode;
  msbw_mode_t mode;
  msbw_mode_t next_mode;
  logic latched;
  logic next_latched;
  logic [7:0] next_width;
  logic [7:0] next_rdata;
  logic [1:0] next_op_mode;
  logic next_ext_bus_en;
  logic next_ext_addr_en;
  logic next_rom_en;
  logic next_bus16;
  logic next_usb8;
  logic [7:0] area_wide;

  msbw_decode u_decode
  (
    .pins({mode_pin_hi, mode_pin_mid, mode_pin_lo}),
    .mode(pin_mode)
  );

  // strap capture: flops reset to constants, pins sampled on the first enabled edge after release
  always_comb
  begin
    next_mode = mode;
    next_latched = latched;
    next_width = area_bus_width_config;
    if (!latched)
    begin
      next_mode = pin_mode;
      next_latched = 1'b1;
      if (pin_mode == MSBW_MODE4)
        next_width = WIDTH_RESET_WIDE;
      else
        next_width = WIDTH_RESET_NARROW;
    end
    else if (reg_wr && reg_addr == ADDR_WIDTH_CFG)
      next_width = reg_wdata;
  end

  // per-area wide flags kept as a bit loop so the area count is easy to change later
  for (genvar g = 0; g < 8; g = g + 1)
  begin : g_area
    assign area_wide[g] = ~next_width[g];
  end

  // derived outputs, computed from the next state so they line up with it
  always_comb
  begin
    next_op_mode = next_mode;
    next_ext_bus_en = next_latched && (next_mode != MSBW_MODE7);
    next_ext_addr_en = next_latched && (next_mode != MSBW_MODE7);
    next_rom_en = next_latched && (next_mode == MSBW_MODE6 || next_mode == MSBW_MODE7);
    // one narrow area does not narrow the bus; any wide area widens it all
    next_bus16 = next_ext_bus_en && (|area_wide);
    next_usb8 = next_width[USB_AREA_BIT];
    next_rdata = 8'h00;
    if (reg_rd)
    begin
      if (reg_addr == ADDR_WIDTH_CFG)
        next_rdata = area_bus_width_config;
      else if (reg_addr == ADDR_MODE_STATUS)
        next_rdata = {3'h0, rom_en, ext_bus_en, latched, op_mode};
      else
        next_rdata = 8'h00; // unmapped reads zero
    end
  end

  // registers; while clk_en is low everything holds
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      mode <= MSBW_MODE7;
      latched <= 1'b0;
      area_bus_width_config <= WIDTH_RESET_NARROW;
      reg_rdata <= 8'h00;
      op_mode <= 2'h3;
      ext_bus_en <= 1'b0;
      ext_addr_en <= 1'b0;
      rom_en <= 1'b0;
      ext_bus_16bit <= 1'b0;
      usb_area_8bit <= 1'b1;
      mode_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      mode <= next_mode;
      latched <= next_latched;
      area_bus_width_config <= next_width;
      reg_rdata <= next_rdata;
      op_mode <= next_op_mode;
      ext_bus_en <= next_ext_bus_en;
      ext_addr_en <= next_ext_addr_en;
      rom_en <= next_rom_en;
      ext_bus_16bit <= next_bus16;
      usb_area_8bit <= next_usb8;
      mode_valid <= next_latched;
    end
  end

  // mode-dependent outputs once the straps are latched
  a_mode_hold: assert property (@(posedge mclk) disable iff (reset)
    mode_valid && $past(mode_valid) |-> $stable(op_mode))
    else $error("mode changed after latch");
  a_ext_mode7: assert property (@(posedge mclk) disable iff (reset)
    mode_valid |-> (ext_addr_en == (op_mode != 2'h3)))
    else $error("external address enable wrong for mode");
  a_ext_bus: assert property (@(posedge mclk) disable iff (reset)
    mode_valid |-> (ext_bus_en == (op_mode != 2'h3)))
    else $error("external bus enable wrong for mode");
  a_rom_enable: assert property (@(posedge mclk) disable iff (reset)
    mode_valid |-> (rom_en == op_mode[1]))
    else $error("rom enable wrong for mode");
  a_reset_width: assert property (@(posedge mclk) disable iff (reset)
    $rose(mode_valid) |-> (area_bus_width_config == ((op_mode == 2'h0) ? 8'h00 : 8'hFF)))
    else $error("width reset value wrong");
  a_bus_width: assert property (@(posedge mclk) disable iff (reset)
    mode_valid |-> (ext_bus_16bit == (ext_bus_en && area_bus_width_config != 8'hFF)))
    else $error("bus width mode wrong");
  a_usb_follow: assert property (@(posedge mclk) disable iff (reset)
    usb_area_8bit == area_bus_width_config[6])
    else $error("usb width does not follow area 6");
  a_width_write: assert property (@(posedge mclk) disable iff (reset)
    clk_en && mode_valid && reg_wr && reg_addr == ADDR_WIDTH_CFG |=> area_bus_width_config == $past(reg_wdata))
    else $error("width write lost");
  a_mode_decode: assert property (@(posedge mclk) disable iff (reset)
    clk_en && !mode_valid && {mode_pin_hi, mode_pin_mid, mode_pin_lo} == 3'h5 |=> op_mode == 2'h1)
    else $error("mode 5 decode wrong");

  // steps of the strap latch and of the register bus, shared by the checks below
  sequence s_latch_edge;
    clk_en && !mode_valid;
  endsequence
  sequence s_width_write;
    clk_en && mode_valid && reg_wr && reg_addr == ADDR_WIDTH_CFG;
  endsequence
  sequence s_other_write;
    clk_en && mode_valid && reg_wr && reg_addr != ADDR_WIDTH_CFG;
  endsequence
  sequence s_read_cfg;
    clk_en && reg_rd && reg_addr == ADDR_WIDTH_CFG;
  endsequence
  sequence s_read_status;
    clk_en && reg_rd && reg_addr == ADDR_MODE_STATUS;
  endsequence

  // the remaining strap patterns, so every decoded mode is watched
  a_decode_mode4: assert property (@(posedge mclk) disable iff (reset)
    s_latch_edge ##0 ({mode_pin_hi, mode_pin_mid, mode_pin_lo} == MODE_PINS_4) |=> op_mode == 2'h0)
    else $error("mode 4 decode wrong");
  a_decode_mode6: assert property (@(posedge mclk) disable iff (reset)
    s_latch_edge ##0 ({mode_pin_hi, mode_pin_mid, mode_pin_lo} == MODE_PINS_6) |=> op_mode == 2'h2)
    else $error("mode 6 decode wrong");
  a_decode_mode7: assert property (@(posedge mclk) disable iff (reset)
    s_latch_edge ##0 ({mode_pin_hi, mode_pin_mid, mode_pin_lo} == MODE_PINS_7) |=> op_mode == 2'h3)
    else $error("mode 7 decode wrong");
  a_latch_once: assert property (@(posedge mclk) disable iff (reset)
    mode_valid |=> mode_valid)
    else $error("latched mode lost before reset");
  a_mode7_narrow: assert property (@(posedge mclk) disable iff (reset)
    mode_valid && op_mode == 2'h3 |-> !ext_bus_16bit && !ext_addr_en)
    else $error("single-chip mode shows external bus");

  // read data stand for exactly the cycle after the strobe, zero otherwise
  a_read_width: assert property (@(posedge mclk) disable iff (reset)
    s_read_cfg |=> reg_rdata == $past(area_bus_width_config))
    else $error("width read data wrong");
  a_read_status: assert property (@(posedge mclk) disable iff (reset)
    s_read_status |=> reg_rdata == {3'h0, $past(rom_en), $past(ext_bus_en), $past(mode_valid), $past(op_mode)})
    else $error("status read data wrong");
  a_read_idle: assert property (@(posedge mclk) disable iff (reset)
    clk_en && !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not cleared");

  // writes: only the width address lands, and the bus width follows it
  a_width_other: assert property (@(posedge mclk) disable iff (reset)
    s_other_write |=> $stable(area_bus_width_config))
    else $error("write to other address changed width");
  a_usb_write: assert property (@(posedge mclk) disable iff (reset)
    s_width_write |=> usb_area_8bit == $past(reg_wdata[6]))
    else $error("usb width does not follow write");
  a_wide_write: assert property (@(posedge mclk) disable iff (reset)
    s_width_write ##0 (ext_bus_en && reg_wdata != 8'hFF) |=> ext_bus_16bit)
    else $error("wide area did not widen bus");
  a_narrow_write: assert property (@(posedge mclk) disable iff (reset)
    s_width_write ##0 (reg_wdata == 8'hFF) |=> !ext_bus_16bit)
    else $error("all narrow areas left bus wide");

  // a low clock enable must hold the mode, the width register and the latch flag
  a_freeze_hold: assert property (@(posedge mclk) disable iff (reset)
    !clk_en |=> $stable(op_mode) && $stable(area_bus_width_config) && $stable(mode_valid))
    else $error("state moved while clock enable low");
endmodule

// ==== msbw_strap.sv ====
`timescale 1ns/1ps
// board straps: pins follow sel only while reset is held, never while running
module msbw_strap
(
  input wire logic reset,
  input wire logic [2:0] sel,
  output logic mode_pin_hi,
  output logic mode_pin_mid,
  output logic mode_pin_lo
);
  logic [2:0] strap;
  // a strap change outside reset is dropped, as a real board would not move
  // always_latch also runs at time zero, so the first strap is taken without waiting for an event
  always_latch
    if (reset)
      strap <= sel;
  assign {mode_pin_hi, mode_pin_mid, mode_pin_lo} = strap;
endmodule

// ==== tb_top.sv ====
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin fail_count++; $display("Error %s exp %h got %h", n, e, g); end end
module tb_top
  import msbw_pkg::*;
;
  logic mclk = 0, reset = 1, clk_en = 1, reg_wr = 0, reg_rd = 0;
  logic [2:0] sel = 3'h4;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, area_bus_width_config, rd;
  logic [1:0] op_mode;
  logic hi, mid, lo, ext_bus_en, ext_addr_en, rom_en, ext_bus_16bit, usb_area_8bit, mode_valid;
  int fail_count = 0, checks_done = 0;
  always #2.5 mclk = ~mclk;
  msbw_strap strap (.reset(reset), .sel(sel), .mode_pin_hi(hi), .mode_pin_mid(mid), .mode_pin_lo(lo));
  msbw_top dut (.mclk(mclk), .reset(reset), .clk_en(clk_en), .mode_pin_hi(hi), .mode_pin_mid(mid),
    .mode_pin_lo(lo), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .op_mode(op_mode), .ext_bus_en(ext_bus_en), .ext_addr_en(ext_addr_en),
    .rom_en(rom_en), .ext_bus_16bit(ext_bus_16bit), .area_bus_width_config(area_bus_width_config),
    .usb_area_8bit(usb_area_8bit), .mode_valid(mode_valid));
  // one strobe cycle; read data are taken in the cycle after the strobe only
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask
  // straps move only inside reset; a few edges let the latch edge land
  task automatic restart(input logic [2:0] p);
    @(posedge mclk);
    reset <= 1'b1;
    sel <= p;
    repeat (20) @(posedge mclk);
    `CHK("valid_in_reset", 1'b0, mode_valid)
    `CHK("mode_in_reset", 2'h3, op_mode)
    reset <= 1'b0;
    repeat (3) @(posedge mclk);
    #1;
  endtask
  task automatic check_modes();
    logic [1:0] m;
    for (int i = 4; i < 8; i++)
    begin
      restart(i[2:0]);
      m = i[1:0];
      `CHK("op_mode", m, op_mode)
      `CHK("ext_bus_en", m != 2'h3, ext_bus_en)
      `CHK("ext_addr_en", m != 2'h3, ext_addr_en)
      `CHK("rom_en", m[1], rom_en)
      `CHK("width_reset", (m == 2'h0) ? 8'h00 : 8'hFF, area_bus_width_config)
      `CHK("bus16_reset", m == 2'h0, ext_bus_16bit)
      `CHK("usb_reset", m != 2'h0, usb_area_8bit)
      `CHK("mode_valid", 1'b1, mode_valid)
      bus(1'b0, ADDR_MODE_STATUS, 8'h00);
      `CHK("mode_status", {3'h0, m[1], m != 2'h3, 1'b1, m}, rd)
    end
  endtask
  task automatic check_width();
    restart(MODE_PINS_5);
    bus(1'b1, ADDR_WIDTH_CFG, 8'hFE);
    `CHK("usb_area_8bit", 1'b1, usb_area_8bit)
    `CHK("bus16_one", 1'b1, ext_bus_16bit)
    bus(1'b1, 4'h2, 8'h00);
    bus(1'b0, ADDR_WIDTH_CFG, 8'h00);
    `CHK("width_rw", 8'hFE, rd)
    @(posedge mclk);
    #1;
    `CHK("rdata_idle", 8'h00, reg_rdata)
    bus(1'b1, ADDR_WIDTH_CFG, 8'hFF);
    `CHK("bus16_none", 1'b0, ext_bus_16bit)
    `CHK("usb_area_set", 1'b1, usb_area_8bit)
    @(posedge mclk);
    clk_en <= 1'b0;
    bus(1'b1, ADDR_WIDTH_CFG, 8'h00);
    `CHK("width_frozen", 8'hFF, area_bus_width_config)
    @(posedge mclk);
    clk_en <= 1'b1;
    bus(1'b0, 4'h9, 8'h00);
    `CHK("unmapped_rd", 8'h00, rd)
  endtask
  task automatic print_verdict();
    if (fail_count == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // hang guard well past the roughly 145 cycles the run needs
  initial
  begin
    #100000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    check_modes();
    check_width();
    print_verdict();
  end
endmodule
